// ===== tb/pcif_bus_model.sv
// Bus partner: arbiter, one target agent and resolution of the shared lines: control lines pulled up, undriven AD/CBE inverted
`timescale 1ns/1ps
module pcif_bus_model
   import pcif_pkg::*;
#(
   parameter logic [31:0] RD_WORD = 32'h1234_ABCD,
   parameter logic [31:0] T_ADDR  = 32'h8000_0120,
   parameter logic [31:0] T_WD    = 32'h5AA5_3CC3
) (
   input  wire logic     pci_clk,
   input  wire logic     claim,
   input  wire logic     tgo,
   input  pcif_pin_out_s po,
   output pcif_pin_in_s  pins,
   output logic [31:0]   cap_addr,
   output logic [3:0]    cap_cmd,
   output logic [31:0]   cap_wd
);
   logic        act_r   = 1'b0;
   logic        frame_q = 1'b1;
   logic        gnt_n_r = 1'b1;
   logic        par_r   = 1'b0;
   logic [31:0] last_ad = 32'h0;
   logic [3:0]  last_be = 4'h0;
   logic        act_o   = 1'b0;
   logic        gnt_o   = 1'b1;
   logic        par_o   = 1'b0;
   logic [1:0]  mst_r   = 2'h0;
   logic [1:0]  mst_o   = 2'h0;
   wire         rd_drv  = act_o & ~cap_cmd[0];

   // Undriven AD/CBE show the inverse of the last level, never a stale copy
   always_comb
   begin
      pins.ad       = po.ad_oe ? po.ad : (mst_o == 2'h1 ? T_ADDR : (mst_o == 2'h2 ? T_WD :
                      (rd_drv ? RD_WORD : ~last_ad)));
      pins.cbe      = po.cbe_oe ? po.cbe : (mst_o == 2'h1 ? 4'h7 : (mst_o == 2'h2 ? 4'h0 : ~last_be));
      pins.par      = po.par_oe ? po.par : par_o;
      pins.frame_n  = po.frame_oe ? po.frame_n : (mst_o != 2'h1);
      pins.irdy_n   = po.irdy_oe ? po.irdy_n : (mst_o != 2'h2);
      pins.trdy_n   = po.trdy_oe ? po.trdy_n : ~act_o;
      pins.stop_n   = po.stop_oe ? po.stop_n : 1'b1;
      pins.devsel_n = po.devsel_oe ? po.devsel_n : ~act_o;
      pins.idsel    = 1'b0;
      pins.gnt_n    = gnt_o;
   end

   // The port samples a few system clocks after each bus rise, so our lines move mid-cycle
   always @(negedge pci_clk)
   begin
      act_o <= act_r;
      gnt_o <= gnt_n_r;
      par_o <= par_r;
      mst_o <= mst_r;
   end

   always @(posedge pci_clk)
   begin
      last_ad <= pins.ad;
      last_be <= pins.cbe;
      par_r   <= ^{pins.ad, pins.cbe};
      gnt_n_r <= po.req_n;
      frame_q <= pins.frame_n;
      // Single-phase write as initiator, ends when the port shows TRDY
      if (mst_r == 2'h0 && tgo)
         mst_r <= 2'h1;
      else if (mst_r == 2'h1)
         mst_r <= 2'h2;
      else if (mst_r == 2'h2 && !pins.trdy_n)
         mst_r <= 2'h0;
      if (frame_q && !pins.frame_n)
      begin
         cap_addr <= pins.ad;
         cap_cmd  <= pins.cbe;
         act_r    <= claim;
      end
      else if (act_r && !pins.irdy_n)
      begin
         cap_wd <= pins.ad;
         act_r  <= 1'b0;
      end
   end
endmodule : pcif_bus_model

// ===== tb/pcif_port_bench.sv
// Self-checking bench for the PCI bus signal port
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin bad_count++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module pcif_port_bench;
   import pcif_pkg::*;
   localparam logic [31:0] RD_WORD = 32'h1234_ABCD;
   localparam logic [31:0] WD      = 32'hC35A_0F96;
   localparam logic [31:0] T_ADDR  = 32'h8000_0120;
   localparam logic [31:0] T_WD    = 32'h5AA5_3CC3;
   logic          tgo = 1'b0;
   logic          clock = 1'b0, rst = 1'b1, pci_clk = 1'b0, pci_rst_n = 1'b0;
   logic          m_start = 1'b0, irq = 1'b0, claim = 1'b1;
   pcif_mreq_s    m_req = '0;
   logic [31:0]   m_wdata = '0, tgt_base = 32'h8000_0000, t_rdata = '0, rd = '0;
   pcif_pin_in_s  pins_i;
   pcif_pin_out_s pins_o;
   logic          m_busy, m_wnext, m_rvalid, m_done, m_abort, m_stopped, t_rd, t_wr, t_cfg;
   logic [31:0]   m_rdata, t_addr, t_wdata, cap_addr, cap_wd;
   logic [3:0]    t_be, cap_cmd;
   int            bad_count = 0;
   int            num_checks = 0;

   pcif_port dut (.clock, .rst, .pci_clk, .pci_rst_n, .pins_i, .pins_o, .m_start, .m_req,
      .m_wdata, .m_busy, .m_wnext, .m_rvalid, .m_rdata, .m_done, .m_abort, .m_stopped,
      .tgt_base, .t_rdata, .t_rd, .t_wr, .t_cfg, .t_addr, .t_wdata, .t_be, .irq);
   pcif_bus_model #(.RD_WORD(RD_WORD), .T_ADDR(T_ADDR), .T_WD(T_WD)) partner (.pci_clk, .claim, .tgo,
      .po(pins_o), .pins(pins_i),
      .cap_addr, .cap_cmd, .cap_wd);

   always #5 clock = ~clock;
   always #80 pci_clk = ~pci_clk;

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up

   task automatic kick(input logic [3:0] cmd, input logic cl);
      claim   <= cl;
      m_req   <= {cmd, 32'h0000_1A40, 4'h0, LEN_ONE};
      m_wdata <= WD;
      m_start <= 1'b1;
      @(posedge clock);
      m_start <= 1'b0;
   endtask : kick

   task automatic run(input logic [3:0] cmd, input logic cl);
      int i;
      kick(cmd, cl);
      for (i = 0; i < 4000 && m_done !== 1'b1; i++)
      begin
         @(posedge clock);
         if (m_rvalid === 1'b1)
            rd = m_rdata;
      end
      if (i == 4000)
      begin
         bad_count++;
         wrap_up();
      end
      repeat (60) @(posedge clock);
   endtask : run

   task automatic t_write();
      run(4'h7, 1'b1);
      `CHK("addr", 32'h0000_1A40, cap_addr)
      `CHK("cmd", 4'h7, cap_cmd)
      `CHK("wdata", WD, cap_wd)
      `CHK("abort", 1'b0, m_abort)
   endtask : t_write

   task automatic t_read();
      run(4'h6, 1'b1);
      `CHK("rdata", RD_WORD, rd)
      `CHK("stopped", 1'b0, m_stopped)
   endtask : t_read

   task automatic t_abort();
      run(4'h6, 1'b0);
      `CHK("abort", 1'b1, m_abort)
   endtask : t_abort

   task automatic t_irq();
      irq <= 1'b1;
      repeat (8) @(posedge clock);
      `CHK("inta_oe", 1'b1, pins_o.inta_oe)
      `CHK("inta_n", 1'b0, pins_o.inta_n)
      irq <= 1'b0;
      repeat (8) @(posedge clock);
      `CHK("inta_oe", 1'b0, pins_o.inta_oe)
   endtask : t_irq

   // Partner writes one word into our target window
   task automatic t_target();
      int i;
      claim <= 1'b0;
      tgo   <= 1'b1;
      repeat (20) @(posedge clock);
      tgo   <= 1'b0;
      for (i = 0; i < 2000 && t_wr !== 1'b1; i++)
         @(posedge clock);
      if (i == 2000)
      begin
         bad_count++;
         wrap_up();
      end
      `CHK("t_addr", T_ADDR, t_addr)
      `CHK("t_wdata", T_WD, t_wdata)
      `CHK("t_be", 4'h0, t_be)
      `CHK("t_cfg", 1'b0, t_cfg)
      repeat (60) @(posedge clock);
      `CHK("perr_oe", 1'b0, pins_o.perr_oe)
      `CHK("serr_oe", 1'b0, pins_o.serr_oe)
   endtask : t_target

   // Reset lands in mid-transaction, while the master drives its address phase with FRAME asserted
   task automatic t_brst();
      kick(4'h6, 1'b0);
      repeat (40) @(posedge clock);
      pci_rst_n <= 1'b0;
      repeat (10) @(posedge clock);
      `CHK("req_n", 1'b1, pins_o.req_n)
      `CHK("frame_oe", 1'b0, pins_o.frame_oe)
      `CHK("ad_oe", 1'b0, pins_o.ad_oe)
      `CHK("busy", 1'b0, m_busy)
      pci_rst_n <= 1'b1;
      repeat (60) @(posedge clock);
      run(4'h7, 1'b1);
      `CHK("wdata", WD, cap_wd)
   endtask : t_brst

   initial
   begin
      repeat (16) @(posedge clock);
      rst       <= 1'b0;
      pci_rst_n <= 1'b1;
      repeat (60) @(posedge clock);
      t_write();
      t_read();
      t_abort();
      t_irq();
      t_target();
      t_brst();
      wrap_up();
   end
endmodule : pcif_port_bench

// ===== verilog/pcif_pkg.sv
// Constants and types shared by the PCI bus signal port
package pcif_pkg;

   // ***********************
   // Timing and sizes
   // ***********************
   localparam logic [2:0] MABORT_EDGES = 3'h5;
   localparam int         TGT_WIN_LOG2 = 12;
   localparam int         LEN_W        = 5;
   localparam logic [LEN_W-1:0] LEN_ONE = 5'h01;
   localparam logic [LEN_W-1:0] LEN_TWO = 5'h02;

   // ***********************
   // Command decode
   // ***********************
   localparam logic [2:0] CMD_MEM_HI = 3'h3;
   localparam logic [2:0] CMD_CFG_HI = 3'h5;
   localparam int         CMD_WR_BIT = 0;

   typedef enum {ST_IDLE, ST_REQ, ST_MADR, ST_MDAT, ST_TDEC, ST_TRDY, ST_TXFR, ST_TURN} pcif_state_e;

   typedef struct packed {
      logic [31:0] ad;
      logic [3:0]  cbe;
      logic        par;
      logic        frame_n;
      logic        irdy_n;
      logic        trdy_n;
      logic        stop_n;
      logic        devsel_n;
      logic        idsel;
      logic        gnt_n;
   } pcif_pin_in_s;

   localparam int PIN_IN_W = $bits(pcif_pin_in_s);

   typedef struct packed {
      logic [31:0] ad;
      logic        ad_oe;
      logic [3:0]  cbe;
      logic        cbe_oe;
      logic        par;
      logic        par_oe;
      logic        frame_n;
      logic        frame_oe;
      logic        irdy_n;
      logic        irdy_oe;
      logic        trdy_n;
      logic        trdy_oe;
      logic        stop_n;
      logic        stop_oe;
      logic        devsel_n;
      logic        devsel_oe;
      logic        perr_n;
      logic        perr_oe;
      logic        serr_n;
      logic        serr_oe;
      logic        inta_n;
      logic        inta_oe;
      logic        req_n;
   } pcif_pin_out_s;

   typedef struct packed {
      logic [3:0]       cmd;
      logic [31:0]      addr;
      logic [3:0]       be;
      logic [LEN_W-1:0] len;
   } pcif_mreq_s;

   typedef struct packed {
      logic frame;
      logic irdy;
      logic trdy;
      logic trdy_a;
      logic stop;
      logic stop_a;
      logic devsel;
      logic ad_oe;
      logic cbe_oe;
   } pcif_drv_s;

endpackage : pcif_pkg

// ===== verilog/pcif_port.sv
// PCI bus signal port: master and target sequencing, parity, arbitration, interrupt
// Notes on behaviour
// - Master puts address on AD in the first clock FRAME is asserted.
// - Data moves only in clocks where IRDY and TRDY are both asserted.
// - C/BE carries command in address phase, byte enables in data phases.
// - Driver of AD drives even PAR over AD and C/BE one clock later; as target the port folds in its own cbe_r, not the C/BE on the bus.
// - Master asserts FRAME to start, holds during burst, releases on last phase.
// - Master asserts IRDY only when able to complete the data phase.
// - Selected target asserts TRDY only when ready to complete the phase.
// - Target asserts STOP to end a transaction; master then terminates.
// - Configuration accesses are claimed only with IDSEL in the address phase.
// - Target claims with DEVSEL on address hit; master checks DEVSEL claim.
// - REQ is always driven outside reset, asserted when wanting the bus.
// - GNT is ignored during bus reset; master only when granted.
// - Data receiver checks parity and asserts PERR the clock after PAR.
// - Odd parity on an address phase raises SERR on the open-drain line.
// - INTA is open drain, only pulled low while service is needed.
// - Bus reset is synchronised internally before use.
// - All bus timing follows the bus clock, up to 33 MHz; REQ falls and INTA moves on the system clock, off the bus edge.
// - A released sustained signal is driven high one clock, then floated.
`timescale 1ns/1ps

// ***********************
// Three-stage input synchroniser
// ***********************
module pcif_sync #(
   parameter int         W  = 1,
   parameter logic [W-1:0] RV = '0
) (
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] q_r;
   wire  [W-1:0] agree_w = ~(s2_r ^ s3_r);

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         s1_r <= RV;
         s2_r <= RV;
         s3_r <= RV;
         q_r  <= RV;
      end
      else
      begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q_r  <= (agree_w & s2_r) | (~agree_w & q_r);
      end
   end
   assign q = q_r;
endmodule : pcif_sync

// ***********************
// Sustained three-state pin with release park
// ***********************
module pcif_sts (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic en,
   input  wire logic clr,
   input  wire logic own,
   input  wire logic act,
   output logic      o,
   output logic      oe
);
   logic d_r;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         d_r <= 1'b0;
      else if (clr)
         d_r <= 1'b0;
      else if (en)
         d_r <= own;
   end
   // Parked high for one bus clock after ownership drops
   assign oe = own | d_r;
   assign o  = own ? ~act : 1'b1;
endmodule : pcif_sts

// ***********************
// Port top
// ***********************
module pcif_port
   import pcif_pkg::*;
(
   input  wire logic          clock,
   input  wire logic          rst,
   input  wire logic          pci_clk,
   input  wire logic          pci_rst_n,
   input  pcif_pin_in_s       pins_i,
   output pcif_pin_out_s      pins_o,
   input  wire logic          m_start,
   input  pcif_mreq_s         m_req,
   input  wire logic [31:0]   m_wdata,
   output logic               m_busy,
   output logic               m_wnext,
   output logic               m_rvalid,
   output logic [31:0]        m_rdata,
   output logic               m_done,
   output logic               m_abort,
   output logic               m_stopped,
   input  wire logic [31:0]   tgt_base,
   input  wire logic [31:0]   t_rdata,
   output logic               t_rd,
   output logic               t_wr,
   output logic               t_cfg,
   output logic [31:0]        t_addr,
   output logic [31:0]        t_wdata,
   output logic [3:0]         t_be,
   input  wire logic          irq
);

   // ***********************
   // Input crossing and bus clock edge
   // ***********************
   logic         pclk_s;
   logic         prst_n_s;
   pcif_pin_in_s pin_s;
   logic         pclk_d_r;

   pcif_sync #(.W(1), .RV(1'b0)) u_sclk (
      .clock(clock), .rst(rst), .d(pci_clk), .q(pclk_s));
   pcif_sync #(.W(1), .RV(1'b0)) u_srst (
      .clock(clock), .rst(rst), .d(pci_rst_n), .q(prst_n_s));
   pcif_sync #(.W(PIN_IN_W), .RV('1)) u_spin (
      .clock(clock), .rst(rst), .d(pins_i), .q(pin_s));

   // Sampling at 100 MHz leaves little margin near 33 MHz
   wire edge_w = pclk_s & ~pclk_d_r;
   wire brst_w = ~prst_n_s;

   // ***********************
   // State
   // ***********************
   pcif_state_e      st_r, st_nxt;
   pcif_drv_s        drv_r, drv_nxt;
   pcif_mreq_s       mq_r, mq_nxt;
   logic [31:0]      ad_r, ad_nxt;
   logic [3:0]       cbe_r, cbe_nxt;
   logic [LEN_W-1:0] rem_r, rem_nxt;
   logic             last_r, last_nxt;
   logic             dsel_r, dsel_nxt;
   logic [2:0]       dcnt_r, dcnt_nxt;
   logic [3:0]       tcmd_r, tcmd_nxt;
   logic [31:0]      taddr_r, taddr_nxt;
   logic [31:0]      twd_r, twd_nxt;
   logic [3:0]       tbe_r, tbe_nxt;
   logic [31:0]      rd_r, rd_nxt;
   logic             ab_r, ab_nxt;
   logic             sp_r, sp_nxt;
   logic             wn_r, wn_nxt;
   logic             rv_r, rv_nxt;
   logic             dn_r, dn_nxt;
   logic             tw_r, tw_nxt;
   logic             trd_r, trd_nxt;
   logic             par_r, par_oe_r;
   logic             frm_prev_r;
   logic             pv_r, pp_r, pe_r;
   logic             ac_r, ap_r, serr_r;
   logic             inta_r;

   // ***********************
   // Decode
   // ***********************
   wire xfer_w   = ~pin_s.irdy_n & ~pin_s.trdy_n;
   wire adr_ph_w = ~pin_s.frame_n & frm_prev_r;
   wire win_w    = pin_s.ad[31:TGT_WIN_LOG2] == tgt_base[31:TGT_WIN_LOG2];
   wire mem_w    = pin_s.cbe[3:1] == CMD_MEM_HI;
   wire cfg_w    = (pin_s.cbe[3:1] == CMD_CFG_HI) & pin_s.idsel;
   wire hit_w    = (mem_w & win_w) | cfg_w;
   wire idle_w   = pin_s.frame_n & pin_s.irdy_n;
   wire gnt_w    = ~pin_s.gnt_n & ~brst_w;
   wire mab_w    = ~dsel_r & (dcnt_r == MABORT_EDGES);
   wire stop_w   = ~pin_s.stop_n;
   wire mwr_w    = mq_r.cmd[CMD_WR_BIT];
   wire twr_w    = tcmd_r[CMD_WR_BIT];
   wire rx_w     = ((st_r == ST_MDAT) & ~mwr_w & xfer_w) | ((st_r == ST_TXFR) & twr_w & xfer_w);
   wire bus_par  = ^{pin_s.ad, pin_s.cbe};

   // ***********************
   // Sequencer
   // ***********************
   always_comb
   begin
      st_nxt    = st_r;
      drv_nxt   = drv_r;
      mq_nxt    = mq_r;
      ad_nxt    = ad_r;
      cbe_nxt   = cbe_r;
      rem_nxt   = rem_r;
      last_nxt  = last_r;
      dsel_nxt  = dsel_r;
      dcnt_nxt  = dcnt_r;
      tcmd_nxt  = tcmd_r;
      taddr_nxt = taddr_r;
      twd_nxt   = twd_r;
      tbe_nxt   = tbe_r;
      rd_nxt    = rd_r;
      ab_nxt    = ab_r;
      sp_nxt    = sp_r;
      wn_nxt    = 1'b0;
      rv_nxt    = 1'b0;
      dn_nxt    = 1'b0;
      tw_nxt    = 1'b0;
      trd_nxt   = 1'b0;
      unique case (st_r)
         ST_IDLE:
         begin
            // A claim on the bus beats a local request in the same cycle
            if (edge_w & adr_ph_w & hit_w)
            begin
               tcmd_nxt  = pin_s.cbe;
               taddr_nxt = pin_s.ad;
               st_nxt    = ST_TDEC;
            end
            else if (m_start)
            begin
               mq_nxt = m_req;
               st_nxt = ST_REQ;
            end
         end
         ST_REQ:
         begin
            if (edge_w & gnt_w & idle_w)
            begin
               drv_nxt.frame  = 1'b1;
               drv_nxt.ad_oe  = 1'b1;
               drv_nxt.cbe_oe = 1'b1;
               ad_nxt         = mq_r.addr;
               cbe_nxt        = mq_r.cmd;
               rem_nxt        = mq_r.len;
               last_nxt       = 1'b0;
               st_nxt         = ST_MADR;
            end
         end
         ST_MADR:
         begin
            if (edge_w)
            begin
               drv_nxt.irdy  = 1'b1;
               cbe_nxt       = mq_r.be;
               drv_nxt.ad_oe = mwr_w;
               if (mwr_w)
               begin
                  ad_nxt = m_wdata;
                  wn_nxt = 1'b1;
               end
               if (rem_r == LEN_ONE)
               begin
                  drv_nxt.frame = 1'b0;
                  last_nxt      = 1'b1;
               end
               dsel_nxt = 1'b0;
               dcnt_nxt = 3'h0;
               ab_nxt   = 1'b0;
               sp_nxt   = 1'b0;
               st_nxt   = ST_MDAT;
            end
         end
         ST_MDAT:
         begin
            if (edge_w)
            begin
               dsel_nxt = dsel_r | ~pin_s.devsel_n;
               if (dcnt_r != MABORT_EDGES)
                  dcnt_nxt = dcnt_r + 3'h1;
               if (xfer_w & ~mwr_w)
               begin
                  rd_nxt = pin_s.ad;
                  rv_nxt = 1'b1;
               end
               if (last_r & (xfer_w | stop_w | mab_w))
               begin
                  drv_nxt.irdy   = 1'b0;
                  drv_nxt.ad_oe  = 1'b0;
                  drv_nxt.cbe_oe = 1'b0;
                  ab_nxt         = mab_w & ~xfer_w;
                  sp_nxt         = stop_w;
                  dn_nxt         = 1'b1;
                  st_nxt         = ST_TURN;
               end
               else
               begin
                  if (mab_w | stop_w | (xfer_w & (rem_r == LEN_TWO)))
                  begin
                     drv_nxt.frame = 1'b0;
                     last_nxt      = 1'b1;
                  end
                  if (xfer_w)
                  begin
                     rem_nxt = rem_r - LEN_ONE;
                     if (mwr_w)
                     begin
                        ad_nxt = m_wdata;
                        wn_nxt = 1'b1;
                     end
                  end
               end
            end
         end
         ST_TDEC:
         begin
            if (edge_w)
            begin
               drv_nxt.devsel = 1'b1;
               drv_nxt.trdy   = 1'b1;
               drv_nxt.trdy_a = 1'b0;
               drv_nxt.stop   = 1'b1;
               drv_nxt.stop_a = 1'b0;
               trd_nxt        = ~twr_w;
               st_nxt         = ST_TRDY;
            end
         end
         ST_TRDY:
         begin
            if (edge_w)
            begin
               // Single-word target: data goes out with a disconnect
               drv_nxt.trdy_a = 1'b1;
               drv_nxt.stop_a = 1'b1;
               drv_nxt.ad_oe  = ~twr_w;
               if (~twr_w)
                  ad_nxt = t_rdata;
               st_nxt = ST_TXFR;
            end
         end
         ST_TXFR:
         begin
            if (edge_w & (xfer_w | idle_w))
            begin
               if (xfer_w & twr_w)
               begin
                  twd_nxt = pin_s.ad;
                  tbe_nxt = pin_s.cbe;
                  tw_nxt  = 1'b1;
               end
               drv_nxt = '0;
               st_nxt  = ST_TURN;
            end
         end
         ST_TURN:
         begin
            if (edge_w)
               st_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         st_r     <= ST_IDLE;
         drv_r    <= '0;
         mq_r     <= '0;
         ad_r     <= 32'h0000_0000;
         cbe_r    <= 4'h0;
         rem_r    <= '0;
         last_r   <= 1'b0;
         dsel_r   <= 1'b0;
         dcnt_r   <= 3'h0;
         tcmd_r   <= 4'h0;
         taddr_r  <= 32'h0000_0000;
         ab_r     <= 1'b0;
         sp_r     <= 1'b0;
      end
      else if (brst_w)
      begin
         st_r  <= ST_IDLE;
         drv_r <= '0;
      end
      else
      begin
         st_r     <= st_nxt;
         drv_r    <= drv_nxt;
         mq_r     <= mq_nxt;
         ad_r     <= ad_nxt;
         cbe_r    <= cbe_nxt;
         rem_r    <= rem_nxt;
         last_r   <= last_nxt;
         dsel_r   <= dsel_nxt;
         dcnt_r   <= dcnt_nxt;
         tcmd_r   <= tcmd_nxt;
         taddr_r  <= taddr_nxt;
         ab_r     <= ab_nxt;
         sp_r     <= sp_nxt;
      end
   end

   // User-side data and pulses
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         {twd_r, tbe_r, rd_r} <= '0;
         {wn_r, rv_r, dn_r, tw_r, trd_r} <= 5'h00;
      end
      else
      begin
         {twd_r, tbe_r, rd_r} <= {twd_nxt, tbe_nxt, rd_nxt};
         {wn_r, rv_r, dn_r, tw_r, trd_r} <= {wn_nxt, rv_nxt, dn_nxt, tw_nxt, trd_nxt};
      end
   end

   // ***********************
   // Parity, errors, interrupt
   // ***********************
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         {par_r, par_oe_r, pv_r, pp_r, pe_r} <= 5'h00;
         {ac_r, ap_r, serr_r, inta_r} <= 4'h0;
         frm_prev_r <= 1'b1;
         pclk_d_r   <= 1'b0;
      end
      else
      begin
         pclk_d_r <= pclk_s;
         inta_r   <= irq & ~brst_w;
         if (brst_w)
         begin
            {par_oe_r, pv_r, pe_r, ac_r, serr_r} <= 5'h00;
            frm_prev_r <= 1'b1;
         end
         else if (edge_w)
         begin
            par_r      <= ^{ad_r, cbe_r};
            par_oe_r   <= drv_r.ad_oe;
            pv_r       <= rx_w;
            pp_r       <= bus_par;
            pe_r       <= pv_r & (pp_r ^ pin_s.par);
            ac_r       <= adr_ph_w;
            ap_r       <= bus_par;
            serr_r     <= ac_r & (ap_r ^ pin_s.par);
            frm_prev_r <= pin_s.frame_n;
         end
      end
   end

   // ***********************
   // Pins
   // ***********************
   pcif_sts u_frame (.clock(clock), .rst(rst), .en(edge_w), .clr(brst_w), .own(drv_r.frame),
      .act(1'b1), .o(pins_o.frame_n), .oe(pins_o.frame_oe));
   pcif_sts u_irdy (.clock(clock), .rst(rst), .en(edge_w), .clr(brst_w), .own(drv_r.irdy),
      .act(1'b1), .o(pins_o.irdy_n), .oe(pins_o.irdy_oe));
   pcif_sts u_trdy (.clock(clock), .rst(rst), .en(edge_w), .clr(brst_w), .own(drv_r.trdy),
      .act(drv_r.trdy_a), .o(pins_o.trdy_n), .oe(pins_o.trdy_oe));
   pcif_sts u_stop (.clock(clock), .rst(rst), .en(edge_w), .clr(brst_w), .own(drv_r.stop),
      .act(drv_r.stop_a), .o(pins_o.stop_n), .oe(pins_o.stop_oe));
   pcif_sts u_dsel (.clock(clock), .rst(rst), .en(edge_w), .clr(brst_w), .own(drv_r.devsel),
      .act(1'b1), .o(pins_o.devsel_n), .oe(pins_o.devsel_oe));
   pcif_sts u_perr (.clock(clock), .rst(rst), .en(edge_w), .clr(brst_w), .own(pe_r),
      .act(1'b1), .o(pins_o.perr_n), .oe(pins_o.perr_oe));

   assign pins_o.ad      = ad_r;
   assign pins_o.ad_oe   = drv_r.ad_oe;
   assign pins_o.cbe     = cbe_r;
   assign pins_o.cbe_oe  = drv_r.cbe_oe;
   assign pins_o.par     = par_r;
   assign pins_o.par_oe  = par_oe_r;
   assign pins_o.serr_n  = 1'b0;
   assign pins_o.serr_oe = serr_r;
   assign pins_o.inta_n  = 1'b0;
   assign pins_o.inta_oe = inta_r;
   assign pins_o.req_n   = ~(st_r == ST_REQ);

   assign m_busy    = st_r != ST_IDLE;
   assign m_wnext   = wn_r;
   assign m_rvalid  = rv_r;
   assign m_rdata   = rd_r;
   assign m_done    = dn_r;
   assign m_abort   = ab_r;
   assign m_stopped = sp_r;
   assign t_rd      = trd_r;
   assign t_wr      = tw_r;
   assign t_cfg     = tcmd_r[3:1] == CMD_CFG_HI;
   assign t_addr    = taddr_r;
   assign t_wdata   = twd_r;
   assign t_be      = tbe_r;

   // ***********************
   // Checks
   // ***********************
   AST_ADDR_PHASE: assert property (@(posedge clock) disable iff (rst)
      $rose(drv_r.frame) |-> drv_r.ad_oe && ad_r == mq_r.addr && cbe_r == mq_r.cmd)
      else $error("address phase without address and command");
   AST_PAR_GEN: assert property (@(posedge clock) disable iff (rst || brst_w)
      edge_w |=> par_r == ^{$past(ad_r), $past(cbe_r)})
      else $error("parity not even over previous lines");
   AST_GRANTED: assert property (@(posedge clock) disable iff (rst)
      st_r == ST_MADR && $past(st_r) == ST_REQ |-> $past(gnt_w))
      else $error("master started without grant");
   AST_RST_FLOAT: assert property (@(posedge clock) disable iff (rst)
      brst_w |=> !pins_o.frame_oe && !pins_o.ad_oe && !pins_o.trdy_oe && !pins_o.devsel_oe)
      else $error("bus output driven during reset");
   AST_PARK: assert property (@(posedge clock) disable iff (rst || brst_w)
      $fell(drv_r.irdy) |-> pins_o.irdy_oe && pins_o.irdy_n)
      else $error("released signal not parked high");
   AST_INTA: assert property (@(posedge clock) disable iff (rst)
      irq && !brst_w |=> pins_o.inta_oe && !pins_o.inta_n)
      else $error("interrupt line not pulled low");
   AST_CFG_IDSEL: assert property (@(posedge clock) disable iff (rst)
      st_r == ST_TDEC && $past(st_r) == ST_IDLE && t_cfg |-> $past(pin_s.idsel))
      else $error("config claimed without select");
   AST_TWR_XFER: assert property (@(posedge clock) disable iff (rst)
      t_wr |-> $past(drv_r.trdy_a) && $past(xfer_w))
      else $error("target write without both ready");
   AST_STOP_END: assert property (@(posedge clock) disable iff (rst || brst_w)
      edge_w && st_r == ST_MDAT && stop_w |=> !drv_r.frame)
      else $error("frame held after stop");
   AST_REQ: assert property (@(posedge clock) disable iff (rst || brst_w)
      st_r == ST_IDLE && m_start && !edge_w |=> !pins_o.req_n)
      else $error("request not raised");
   AST_SERR: assert property (@(posedge clock) disable iff (rst || brst_w)
      edge_w && ac_r && (ap_r ^ pin_s.par) |=> pins_o.serr_oe ##1 !edge_w || !pins_o.serr_oe)
      else $error("address parity error not signalled");
endmodule : pcif_port
